//--- verilog/wdt_defs.vh
// constants for the watchdog timer: offsets, fields, reset values, timing
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WDT_RST_CTRL_ADDR 8'hAB
`define WDT_MAIN_CTRL_ADDR 8'hD8
`define WDT_EIE_ADDR 8'hE8
`define WDT_TA_ADDR 8'h9F
`define WDT_EVT_STATUS_ADDR 8'hF8
`define WDT_EVT_MASK_ADDR 8'hF9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDT_RUN_EN_BIT 7
`define WDT_CLEAR_BIT 6
`define WDT_TOFLAG_BIT 5
`define WDT_LOWPWR_BIT 4
`define WDT_RSTCAUSE_BIT 3
`define WDT_PS_MSB 2
`define WDT_PS_LSB 0
`define WDT_RSTEN_BIT 0
`define WDT_WATCHDOG_INTERRUPT_ENABLE_BIT 4
`define WDT_EVT_TIMEOUT 0
`define WDT_EVT_DELAY 1
`define WDT_EVT_COUNT 2

// ----------------------------------------------------------------
// reset values and unlock keys
// ----------------------------------------------------------------
`define WDT_EIE_RESET 8'h00
`define WDT_PS_RESET 3'h0
`define WDT_TA_KEY1 8'hAA
`define WDT_TA_KEY2 8'h55

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WDT_CORE_CLK_PERIOD_NS 20
`define WDT_LS_CLK_PERIOD_NS 100000
`define WDT_TICK_CYCLES (`WDT_LS_CLK_PERIOD_NS / `WDT_CORE_CLK_PERIOD_NS)
`define WDT_BASE_TICKS 64
`define WDT_RST_DELAY_TICKS 512

`endif

//--- verilog/wdt_tick_div.v
// divider making the low-speed watchdog clock enable from the core clock
`timescale 1ns/1ns
module wdt_tick_div #(
    parameter DIV = 5000
) (
    input wire clk_i,
    input wire rst_n_i,
    output reg tick_o
);

localparam CW = $clog2(DIV);
localparam [31:0] LAST_FULL = DIV - 1;
localparam [CW-1:0] LAST = LAST_FULL[CW-1:0];

reg [CW-1:0] cnt;

// free-running count, one pulse per low-speed period
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        cnt <= {CW{1'b0}};
        tick_o <= 1'b0;
    end else if (cnt == LAST) begin
        cnt <= {CW{1'b0}};
        tick_o <= 1'b1;
    end else begin
        cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
        tick_o <= 1'b0;
    end
end

endmodule // wdt_tick_div

//--- verilog/wdt_event_flags.v
// sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ns
module wdt_event_flags #(
    parameter N = 3
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire [N-1:0] evt_i,
    input wire wr_status_i,
    input wire wr_mask_i,
    input wire [N-1:0] wdata_i,
    output wire [N-1:0] status_o,
    output wire [N-1:0] mask_o,
    output reg irq_o
);

reg [N-1:0] status;
reg [N-1:0] mask;

genvar g;
generate
    for (g = 0; g < N; g = g + 1) begin : g_flag
        // set wins over a clear in the same cycle
        always @(posedge clk_i) begin
            if (!rst_n_i) begin
                status[g] <= 1'b0;
            end else if (evt_i[g]) begin
                status[g] <= 1'b1;
            end else if (wr_status_i && wdata_i[g]) begin
                status[g] <= 1'b0;
            end
        end
    end
endgenerate

// mask register and interrupt level
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        mask <= {N{1'b0}};
        irq_o <= 1'b0;
    end else begin
        if (wr_mask_i) begin
            mask <= wdata_i;
        end
        irq_o <= |(status & mask);
    end
end

assign status_o = status;
assign mask_o = mask;

endmodule // wdt_event_flags

//--- verilog/watchdog_timer.v
// watchdog timer with time-out flag, delayed system reset and timed-access protection
//
// Behaviour
// - writing one to counter-clear zeroes the counter; the bit clears itself.
// - clearing run-enable stops the timer and clears the counter.
// - with run-enable set the counter advances on each low-speed tick.
// - period-select picks 64 ticks times 1,2,8,16,32,64,128,256.
// - each elapsed interval sets the time-out flag in hardware.
// - interrupt request from the flag only while its enable bit is set.
// - with reset enabled, 512 ticks after time-out without clear, system reset.
// - reset-enable bit turns the watchdog reset function off or on.
// - reset-cause flag: zero at power-on, set by watchdog reset, software clears.
// - low-power-run zero halts counting in idle or power down.
// - counter is cleared on entry into and wake from idle or power down.
// - every reset loads run-enable with the inverse configuration bit.
// - low-power-run and period-select clear at power-on, kept otherwise.
// - reset-enable clears at power-on, kept through other resets.
// - both watchdog control registers accept writes only after unlock.
// - counter runs from a nominal 10 kHz low-speed clock.
// - a completed interval also wakes the system from low power.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
`include "wdt_defs.vh"
module watchdog_timer #(
    parameter TICK_DIV = `WDT_TICK_CYCLES,
    parameter CNT_W = 15,
    parameter DLY_W = 10
) (
    input wire CORE_CLK_I,
    input wire RSTN_I,
    input wire POR_I,
    input wire CFG_WDT_DISABLE_I,
    input wire IDLE_I,
    input wire PDOWN_I,
    input wire [7:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    output reg [7:0] RDATA_O,
    output reg IRQ_O,
    output reg WAKE_O,
    output reg SYS_RESET_O
);

// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
localparam [2:0] TA_IDLE = 3'b001;
localparam [2:0] TA_KEY1 = 3'b010;
localparam [2:0] TA_OPEN = 3'b100;
// full-width copies first, then cut to the counter widths on purpose
localparam [31:0] DLY_LAST_FULL = `WDT_RST_DELAY_TICKS - 1;
localparam [31:0] BASE_FULL = `WDT_BASE_TICKS;
localparam [DLY_W-1:0] DLY_LAST = DLY_LAST_FULL[DLY_W-1:0];
localparam [CNT_W-1:0] BASE = BASE_FULL[CNT_W-1:0];
localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};
localparam EVT_N = 3;

// interval length in ticks for a period-select code
// there is no 4x step: code 2 jumps straight to 8x
function [CNT_W-1:0] period_ticks;
    input [2:0] code;
    begin
        case (code)
            3'h0: period_ticks = BASE;
            3'h1: period_ticks = BASE << 1;
            3'h2: period_ticks = BASE << 3;
            3'h3: period_ticks = BASE << 4;
            3'h4: period_ticks = BASE << 5;
            3'h5: period_ticks = BASE << 6;
            3'h6: period_ticks = BASE << 7;
            default: period_ticks = BASE << 8;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg run_enable;
reg run_in_low_power;
reg [2:0] period_select;
reg timeout_interrupt_flag;
reg watchdog_reset_cause_flag;
reg reset_function_enable;
reg [7:0] extended_interrupt_enable;
reg [CNT_W-1:0] count;
reg delay_active;
reg [DLY_W-1:0] delay_count;
reg low_power_prev;
reg [2:0] ta_state;

wire tick;
wire [EVT_N-1:0] evt_status;
wire [EVT_N-1:0] evt_mask;
wire evt_irq;

// ----------------------------------------------------------------
// low-speed clock enable
// ----------------------------------------------------------------
// one pulse per low-speed period stands in for the RC clock
wdt_tick_div #(
    .DIV(TICK_DIV)
) u_tick (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .tick_o(tick)
);

// ----------------------------------------------------------------
// bus decode and timed access
// ----------------------------------------------------------------
// unlock state opens the protected registers for one write
// reads never move the unlock state, only writes do
wire ta_open = (ta_state == TA_OPEN);
wire wr_main = WR_I && (ADDR_I == `WDT_MAIN_CTRL_ADDR) && ta_open;
wire wr_rstc = WR_I && (ADDR_I == `WDT_RST_CTRL_ADDR) && ta_open;
wire wr_eie = WR_I && (ADDR_I == `WDT_EIE_ADDR);
wire wr_ta = WR_I && (ADDR_I == `WDT_TA_ADDR);
wire wr_evt_status = WR_I && (ADDR_I == `WDT_EVT_STATUS_ADDR);
wire wr_evt_mask = WR_I && (ADDR_I == `WDT_EVT_MASK_ADDR);

// any write other than the key sequence locks again
always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
        ta_state <= TA_IDLE;
    end else if (WR_I) begin
        case (ta_state)
            TA_KEY1: begin
                if (wr_ta && WDATA_I == `WDT_TA_KEY2) begin
                    ta_state <= TA_OPEN;
                end else if (wr_ta && WDATA_I == `WDT_TA_KEY1) begin
                    ta_state <= TA_KEY1;
                end else begin
                    ta_state <= TA_IDLE;
                end
            end
            // open or idle: any write consumes the unlock
            default: begin
                if (wr_ta && WDATA_I == `WDT_TA_KEY1) begin
                    ta_state <= TA_KEY1;
                end else begin
                    ta_state <= TA_IDLE;
                end
            end
        endcase
    end
end

// ----------------------------------------------------------------
// counting conditions
// ----------------------------------------------------------------
// low power covers both idle and power down
// entry and wake both clear, so a long sleep leaves no stale count
wire low_power = IDLE_I | PDOWN_I;
wire low_power_edge = low_power ^ low_power_prev;
wire clear_write = wr_main && WDATA_I[`WDT_CLEAR_BIT];
wire disable_write = wr_main && !WDATA_I[`WDT_RUN_EN_BIT];
wire count_clear = clear_write || disable_write || !run_enable || low_power_edge;
wire run_gate = run_enable && (!low_power || run_in_low_power);
wire counting = run_gate && tick;
wire [CNT_W-1:0] limit = period_ticks(period_select);
// a clear in the same cycle wins over the interval end
wire timeout = counting && !count_clear && (count == limit - ONE);

// ----------------------------------------------------------------
// watchdog counter
// ----------------------------------------------------------------
// restarts after each interval so the flag repeats periodically
// edge detector resets to the idle level, so no false edge follows reset
always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
        count <= {CNT_W{1'b0}};
        low_power_prev <= 1'b0;
    end else begin
        low_power_prev <= low_power;
        if (count_clear) begin
            count <= {CNT_W{1'b0}};
        end else if (timeout) begin
            count <= {CNT_W{1'b0}};
        end else if (counting) begin
            count <= count + ONE;
        end
    end
end

// ----------------------------------------------------------------
// reset delay
// ----------------------------------------------------------------
// last gated tick of the window with nothing cancelling it
wire reset_fire = delay_active && run_gate && tick && (delay_count == DLY_LAST) && !count_clear &&
    reset_function_enable;

// clearing the counter in the window cancels the pending reset
// a second time-out inside the window does not restart it
always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
        delay_active <= 1'b0;
        delay_count <= {DLY_W{1'b0}};
        SYS_RESET_O <= 1'b0;
    end else begin
        SYS_RESET_O <= 1'b0;
        if (count_clear || !reset_function_enable) begin
            delay_active <= 1'b0;
            delay_count <= {DLY_W{1'b0}};
        end else if (delay_active) begin
            if (run_gate && tick) begin
                if (delay_count == DLY_LAST) begin
                    delay_active <= 1'b0;
                    SYS_RESET_O <= 1'b1;
                end else begin
                    delay_count <= delay_count + {{(DLY_W-1){1'b0}}, 1'b1};
                end
            end
        end else if (timeout) begin
            delay_active <= 1'b1;
            delay_count <= {DLY_W{1'b0}};
        end
    end
end

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
// power-on clears retained fields; other resets keep them
// run-enable reloads on every reset, power-on or not
always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
        run_enable <= ~CFG_WDT_DISABLE_I;
        timeout_interrupt_flag <= 1'b0;
        extended_interrupt_enable <= `WDT_EIE_RESET;
        if (POR_I) begin
            run_in_low_power <= 1'b0;
            period_select <= `WDT_PS_RESET;
            reset_function_enable <= 1'b0;
            watchdog_reset_cause_flag <= 1'b0;
        end
    end else begin
        if (wr_main) begin
            run_enable <= WDATA_I[`WDT_RUN_EN_BIT];
            run_in_low_power <= WDATA_I[`WDT_LOWPWR_BIT];
            period_select <= WDATA_I[`WDT_PS_MSB:`WDT_PS_LSB];
        end
        // hardware set wins over a software write
        if (timeout) begin
            timeout_interrupt_flag <= 1'b1;
        end else if (wr_main) begin
            timeout_interrupt_flag <= WDATA_I[`WDT_TOFLAG_BIT];
        end
        // cause flag set as the watchdog reset goes out
        if (reset_fire) begin
            watchdog_reset_cause_flag <= 1'b1;
        end else if (wr_main) begin
            watchdog_reset_cause_flag <= WDATA_I[`WDT_RSTCAUSE_BIT];
        end
        if (wr_rstc) begin
            reset_function_enable <= WDATA_I[`WDT_RSTEN_BIT];
        end
        if (wr_eie) begin
            extended_interrupt_enable <= WDATA_I;
        end
    end
end

// ----------------------------------------------------------------
// event flags and interrupt
// ----------------------------------------------------------------
wire [EVT_N-1:0] evt_in;
assign evt_in[`WDT_EVT_TIMEOUT] = timeout;
// delay event marks the arming only, not repeats inside the window
assign evt_in[`WDT_EVT_DELAY] = timeout && reset_function_enable && !delay_active;
assign evt_in[`WDT_EVT_COUNT] = clear_write;

// sticky events with their own mask
wdt_event_flags #(
    .N(EVT_N)
) u_evt (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .evt_i(evt_in),
    .wr_status_i(wr_evt_status),
    .wr_mask_i(wr_evt_mask),
    .wdata_i(WDATA_I[EVT_N-1:0]),
    .status_o(evt_status),
    .mask_o(evt_mask),
    .irq_o(evt_irq)
);

// interrupt level and wake pulse
// flag path and event path share the one level output
always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
        IRQ_O <= 1'b0;
        WAKE_O <= 1'b0;
    end else begin
        IRQ_O <= (timeout_interrupt_flag && extended_interrupt_enable[`WDT_WATCHDOG_INTERRUPT_ENABLE_BIT]) || evt_irq;
        WAKE_O <= timeout;
    end
end

// ----------------------------------------------------------------
// read back
// ----------------------------------------------------------------
// read image of the main control register, clear bit always zero
wire [7:0] main_image = {run_enable, 1'b0, timeout_interrupt_flag, run_in_low_power,
                         watchdog_reset_cause_flag, period_select};

// data stands one cycle after the strobe, zero otherwise
always @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
        RDATA_O <= 8'h00;
    end else if (RD_I) begin
        case (ADDR_I)
            `WDT_MAIN_CTRL_ADDR: begin
                RDATA_O <= main_image;
            end
            `WDT_RST_CTRL_ADDR: begin
                RDATA_O <= {7'h00, reset_function_enable};
            end
            `WDT_EIE_ADDR: begin
                RDATA_O <= extended_interrupt_enable;
            end
            `WDT_TA_ADDR: begin
                RDATA_O <= 8'h00; // unlock keys never read back
            end
            `WDT_EVT_STATUS_ADDR: begin
                RDATA_O <= {5'h00, evt_status};
            end
            `WDT_EVT_MASK_ADDR: begin
                RDATA_O <= {5'h00, evt_mask};
            end
            default: begin
                RDATA_O <= 8'h00;
            end
        endcase
    end else begin
        RDATA_O <= 8'h00;
    end
end

endmodule // watchdog_timer

//--- test/watchdog_timer_properties.sv
// port-level checker for the watchdog timer
`timescale 1ns/1ns
`include "wdt_defs.vh"
module watchdog_timer_properties #(
    parameter TICK_DIV = `WDT_TICK_CYCLES,
    parameter CNT_W = 15,
    parameter DLY_W = 10
) (
    input wire CORE_CLK_I,
    input wire RSTN_I,
    input wire POR_I,
    input wire CFG_WDT_DISABLE_I,
    input wire IDLE_I,
    input wire PDOWN_I,
    input wire [7:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [7:0] RDATA_O,
    input wire IRQ_O,
    input wire WAKE_O,
    input wire SYS_RESET_O
);
    // ----
    // cycles since reset release, saturating
    // ----
    reg [31:0] up_cnt;
    always @(posedge CORE_CLK_I) begin
        if (!RSTN_I)
            up_cnt <= 32'h0;
        else if (up_cnt != 32'hFFFFFFFF)
            up_cnt <= up_cnt + 32'h1;
    end

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);

    // ----
    // assertions
    // ----
    a_read_idle_zero: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside a read cycle");
    a_clear_reads_zero: assert property ($past(RD_I) && $past(ADDR_I) == `WDT_MAIN_CTRL_ADDR
        |-> !RDATA_O[`WDT_CLEAR_BIT]) else $error("counter clear bit read as one");
    a_resv_reads_zero: assert property ($past(RD_I) && $past(ADDR_I) == `WDT_RST_CTRL_ADDR
        |-> RDATA_O[7:1] == 7'h00) else $error("reserved reset control bits not zero");
    a_wake_one_pulse: assert property (WAKE_O |=> !WAKE_O [*8])
        else $error("wake pulse too long or too close");
    a_sysrst_one_pulse: assert property (SYS_RESET_O |=> !SYS_RESET_O [*8])
        else $error("system reset pulse too long");
    a_sysrst_not_early: assert property (SYS_RESET_O |-> up_cnt >= 575 * TICK_DIV)
        else $error("system reset before time-out plus delay");
    a_irq_has_cause: assert property ($rose(IRQ_O) |-> $past(WAKE_O) || $past(WAKE_O, 2)
        || $past(WR_I) || $past(WR_I, 2) || $past(WR_I, 3)) else $error("interrupt without cause");
    a_reset_quiet: assert property ($rose(RSTN_I) |-> !IRQ_O && !WAKE_O && !SYS_RESET_O)
        else $error("outputs active right after reset");

    // main scenarios
    c_wake: cover property (WAKE_O);
    c_sysrst: cover property (SYS_RESET_O);
    c_irq: cover property ($rose(IRQ_O));
endmodule // watchdog_timer_properties

bind watchdog_timer watchdog_timer_properties #(.TICK_DIV(TICK_DIV), .CNT_W(CNT_W), .DLY_W(DLY_W)) i_props (
    .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .POR_I(POR_I), .CFG_WDT_DISABLE_I(CFG_WDT_DISABLE_I),
    .IDLE_I(IDLE_I), .PDOWN_I(PDOWN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O), .SYS_RESET_O(SYS_RESET_O));

//--- test/tb_watchdog_timer.sv
// self-checking bench for the watchdog timer
`timescale 1ns/1ns
`include "wdt_defs.vh"
module tb_watchdog_timer;
    localparam TD = 4;
    reg CORE_CLK_I = 1'b0;
    reg RSTN_I = 1'b0;
    reg POR_I = 1'b1;
    reg CFG_WDT_DISABLE_I = 1'b0;
    reg IDLE_I = 1'b0;
    reg PDOWN_I = 1'b0;
    reg [7:0] ADDR_I = 8'h00;
    reg [7:0] WDATA_I = 8'h00;
    reg WR_I = 1'b0;
    reg RD_I = 1'b0;
    wire [7:0] RDATA_O;
    wire IRQ_O;
    wire WAKE_O;
    wire SYS_RESET_O;
    integer errors = 0;
    integer check_count = 0;
    integer rst_pulses = 0;
    integer wake_pulses = 0;
    integer n;
    integer k;
    integer p;
    reg [31:0] seed = 32'h7941;

    watchdog_timer #(.TICK_DIV(TD), .CNT_W(15), .DLY_W(10)) i_dut (
        .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .POR_I(POR_I), .CFG_WDT_DISABLE_I(CFG_WDT_DISABLE_I),
        .IDLE_I(IDLE_I), .PDOWN_I(PDOWN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
        .RD_I(RD_I), .RDATA_O(RDATA_O), .IRQ_O(IRQ_O), .WAKE_O(WAKE_O), .SYS_RESET_O(SYS_RESET_O));

    // ----
    // clock, pulse counters, model helpers
    // ----
    initial begin
        forever #10 CORE_CLK_I = ~CORE_CLK_I;
    end
    always @(posedge CORE_CLK_I) begin
        if (SYS_RESET_O === 1'b1) rst_pulses <= rst_pulses + 1;
        if (WAKE_O === 1'b1) wake_pulses <= wake_pulses + 1;
    end
    function integer period_ticks(input [2:0] c);
        period_ticks = 64 * ((c == 3'h0) ? 1 : (c == 3'h1) ? 2 : (1 << (c + 1)));
    endfunction
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    // ----
    // bus tasks and comparison
    // ----
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge CORE_CLK_I);
            ADDR_I <= a;
            WDATA_I <= d;
            WR_I <= 1'b1;
            @(posedge CORE_CLK_I);
            WR_I <= 1'b0;
        end
    endtask
    task tawr(input [7:0] a, input [7:0] d);
        begin
            wr(`WDT_TA_ADDR, `WDT_TA_KEY1);
            wr(`WDT_TA_ADDR, `WDT_TA_KEY2);
            wr(a, d);
        end
    endtask
    task rd_chk(input string nm, input [7:0] a, input [7:0] exp);
        begin
            @(posedge CORE_CLK_I);
            ADDR_I <= a;
            RD_I <= 1'b1;
            @(posedge CORE_CLK_I);
            RD_I <= 1'b0;
            #1;
            chk(nm, RDATA_O, exp);
        end
    endtask
    task wait_for(input sel, input integer lim, output integer cnt);
        begin
            cnt = 0;
            while ((sel ? SYS_RESET_O : WAKE_O) !== 1'b1 && cnt < lim) begin
                @(posedge CORE_CLK_I);
                #1;
                cnt = cnt + 1;
            end
        end
    endtask
    task do_reset(input por, input cfg);
        begin
            @(posedge CORE_CLK_I);
            RSTN_I <= 1'b0;
            POR_I <= por;
            CFG_WDT_DISABLE_I <= cfg;
            repeat (3) @(posedge CORE_CLK_I);
            RSTN_I <= 1'b1;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d, mismatches %0d", check_count, errors);
            if (errors == 0 && check_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    // ----
    // watchdog against hangs
    // ----
    initial begin
        repeat (60000) @(posedge CORE_CLK_I);
        errors = errors + 1;
        report_and_stop;
    end

    // ----
    // scenarios
    // ----
    initial begin
        do_reset(1'b1, 1'b0);
        rd_chk("main ctrl", `WDT_MAIN_CTRL_ADDR, 8'h80);
        rd_chk("reset ctrl", `WDT_RST_CTRL_ADDR, 8'h00);
        rd_chk("int enable", `WDT_EIE_ADDR, `WDT_EIE_RESET);
        wr(`WDT_MAIN_CTRL_ADDR, 8'h17);
        rd_chk("locked write", `WDT_MAIN_CTRL_ADDR, 8'h80);
        rd_chk("unmapped", 8'h10, 8'h00);
        for (k = 0; k < 4; k = k + 1) begin
            seed = xs(seed);
            wr(`WDT_EIE_ADDR, seed[7:0]);
            rd_chk("int enable rw", `WDT_EIE_ADDR, seed[7:0]);
        end
        tawr(`WDT_RST_CTRL_ADDR, 8'hFF);
        rd_chk("reset ctrl", `WDT_RST_CTRL_ADDR, 8'h01);
        tawr(`WDT_MAIN_CTRL_ADDR, 8'h40);
        rd_chk("clear bit", `WDT_MAIN_CTRL_ADDR, 8'h00);
        tawr(`WDT_RST_CTRL_ADDR, 8'h00);
        // time-out length for period codes 0 to 4, with and without interrupt enable
        for (k = 0; k < 5; k = k + 1) begin
            p = period_ticks(k);
            wr(`WDT_EIE_ADDR, k[0] ? 8'h10 : 8'h00);
            tawr(`WDT_MAIN_CTRL_ADDR, 8'h00);
            tawr(`WDT_MAIN_CTRL_ADDR, 8'h80 | k[2:0]);
            wait_for(1'b0, p * TD + 40, n);
            chk("period", n >= (p - 1) * TD && n <= p * TD + 4, 1);
            repeat (3) @(posedge CORE_CLK_I);
            #1;
            chk("irq", IRQ_O, k[0]);
            rd_chk("flag", `WDT_MAIN_CTRL_ADDR, 8'hA0 | k[2:0]);
        end
        // event status raise, mask, clear
        rd_chk("event status", `WDT_EVT_STATUS_ADDR, 8'h05);
        wr(`WDT_EVT_MASK_ADDR, 8'h01);
        repeat (3) @(posedge CORE_CLK_I);
        #1;
        chk("masked irq", IRQ_O, 1);
        wr(`WDT_EVT_STATUS_ADDR, 8'h05);
        repeat (3) @(posedge CORE_CLK_I);
        #1;
        chk("cleared irq", IRQ_O, 0);
        rd_chk("event status", `WDT_EVT_STATUS_ADDR, 8'h00);
        wr(`WDT_EVT_MASK_ADDR, 8'h00);
        // reset delay, then a plain reset keeps the retained fields
        tawr(`WDT_MAIN_CTRL_ADDR, 8'h00);
        tawr(`WDT_RST_CTRL_ADDR, 8'h01);
        tawr(`WDT_MAIN_CTRL_ADDR, 8'h91);
        wait_for(1'b0, 128 * TD + 40, n);
        chk("first interval", n <= 128 * TD + 4, 1);
        wait_for(1'b1, 512 * TD + 40, n);
        chk("reset delay", n >= 511 * TD && n <= 512 * TD + 4, 1);
        rd_chk("delay event", `WDT_EVT_STATUS_ADDR, 8'h03);
        do_reset(1'b0, 1'b1);
        rd_chk("kept fields", `WDT_MAIN_CTRL_ADDR, 8'h19);
        rd_chk("kept reset enable", `WDT_RST_CTRL_ADDR, 8'h01);
        tawr(`WDT_MAIN_CTRL_ADDR, 8'h00);
        rd_chk("cause cleared", `WDT_MAIN_CTRL_ADDR, 8'h00);
        // clearing inside the delay window prevents the reset
        tawr(`WDT_MAIN_CTRL_ADDR, 8'h80);
        wait_for(1'b0, 64 * TD + 40, n);
        chk("window start", n <= 64 * TD + 4, 1);
        k = rst_pulses;
        repeat (300 * TD) @(posedge CORE_CLK_I);
        tawr(`WDT_MAIN_CTRL_ADDR, 8'hC0);
        repeat (400 * TD) @(posedge CORE_CLK_I);
        chk("no reset after clear", rst_pulses, k);
        // idle halts and clears the counter when low-power run is off
        tawr(`WDT_RST_CTRL_ADDR, 8'h00);
        tawr(`WDT_MAIN_CTRL_ADDR, 8'hC0);
        repeat (40 * TD) @(posedge CORE_CLK_I);
        k = wake_pulses;
        IDLE_I <= 1'b1;
        repeat (100 * TD) @(posedge CORE_CLK_I);
        IDLE_I <= 1'b0;
        chk("halted in idle", wake_pulses, k);
        wait_for(1'b0, 64 * TD + 40, n);
        chk("cleared on wake", n >= 63 * TD && n <= 64 * TD + 4, 1);
        // power down with low-power run on keeps counting and wakes
        tawr(`WDT_MAIN_CTRL_ADDR, 8'h90);
        PDOWN_I <= 1'b1;
        wait_for(1'b0, 64 * TD + 40, n);
        chk("power down wake", n >= 63 * TD && n <= 64 * TD + 4, 1);
        PDOWN_I <= 1'b0;
        report_and_stop;
    end
endmodule // tb_watchdog_timer
